// ### hw/mbrh_params.svh
// Constants of the serial read handler: codes, address ranges, timing.
// Assumes a single 25 MHz system clock; included by package and modules.
`ifndef MBRH_PARAMS_SVH
`define MBRH_PARAMS_SVH

// Clock and bit rates
`define MBRH_CLK_HZ       25000000
`define MBRH_OVS          16
`define MBRH_BAUD_0       4800
`define MBRH_BAUD_1       9600
`define MBRH_BAUD_2       19200
`define MBRH_BAUD_3       38400
`define MBRH_BAUD_4       57600
`define MBRH_BAUD_5       115200
`define MBRH_DIV(b)       ((`MBRH_CLK_HZ) / ((b) * `MBRH_OVS))

// Frame silence: half characters and character lengths in bits
`define MBRH_SIL_HALFCH   7
`define MBRH_CHAR_SHORT   10
`define MBRH_CHAR_LONG    11
`define MBRH_SIL_BITS(nb) ((`MBRH_SIL_HALFCH * (nb) + 1) / 2)

// Function codes
`define MBRH_FC_RD_BIT_A  8'h01
`define MBRH_FC_RD_BIT_B  8'h02
`define MBRH_FC_RD_REG_A  8'h03
`define MBRH_FC_RD_REG_B  8'h04
`define MBRH_FC_WR_BIT    8'h05
`define MBRH_FC_WR_REG16  8'h06
`define MBRH_FC_WR_REG32  8'h10

// Bit address map
`define MBRH_DO_LO        16'h000C
`define MBRH_DO_HI        16'h0011
`define MBRH_OF_LO        16'h008D
`define MBRH_OF_HI        16'h00AE
`define MBRH_OF_OFF       16'h00A6
`define MBRH_OF_ON        16'h00A7

// Quantity limits, parameter address scale, frame lengths
`define MBRH_MAX_BITS     16'h07D0
`define MBRH_MAX_REGS     16'h007D
`define MBRH_PAR_SCALE    16'h0064
`define MBRH_QRY_LEN      4'h8
`define MBRH_WR32_MIN     4'h9

// Check sequence
`define MBRH_CRC_INIT     16'hFFFF
`define MBRH_CRC_POLY     16'hA001

`endif

// ### hw/mbrh_pkg.sv
// Types and the shared check-sequence step of the serial read handler.
// Assumes mbrh_params.svh is on the include path.
`include "mbrh_params.svh"
package mbrh_pkg;
	typedef logic [7:0] mbrh_byte_t;

	typedef enum logic [3:0] {
		MBRH_ST_IDLE  = 4'h0,
		MBRH_ST_CHECK = 4'h1,
		MBRH_ST_HDR   = 4'h2,
		MBRH_ST_PREP  = 4'h3,
		MBRH_ST_LATCH = 4'h4,
		MBRH_ST_DATA  = 4'h5,
		MBRH_ST_CRCL  = 4'h6,
		MBRH_ST_CRCH  = 4'h7,
		MBRH_ST_DONE  = 4'h8
	} mbrh_state_t;

	// One byte into the reflected check sequence
	function automatic logic [15:0] mbrh_crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `MBRH_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// ### hw/mbrh_ser_if.sv
// Byte link between the character engine and the frame core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface mbrh_ser_if;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_err;
	logic       rx_busy;
	logic       bit_tick;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       tx_ready;
	logic       txd;

	modport uart (output rx_valid, rx_data, rx_err, rx_busy, bit_tick, tx_ready, txd,
		input tx_valid, tx_data);
	modport core (input rx_valid, rx_data, rx_err, rx_busy, bit_tick, tx_ready, txd,
		output tx_valid, tx_data);
endinterface

// ### hw/mbrh_uart.sv
// Character engine: rate divider, receiver and transmitter.
// Assumes i_rxd is synchronous to i_mclk and idles high.
`timescale 1ns/10ps
`include "mbrh_params.svh"
module mbrh_uart (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_rxd,
	input  wire logic [2:0] i_baud_sel,
	input  wire logic [1:0] i_fmt_sel,
	mbrh_ser_if.uart        ser
);
	import mbrh_pkg::*;

	// Oversample divider per rate code
	function automatic logic [11:0] div_of(input logic [2:0] s);
		case (s)
			3'h0: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_0));
			3'h2: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_2));
			3'h3: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_3));
			3'h4: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_4));
			3'h5: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_5));
			default: div_of = 12'(`MBRH_DIV(`MBRH_BAUD_1));
		endcase
	endfunction

	logic [11:0] div_r;
	logic [3:0]  sub_r;
	logic        bit_tick_r;
	logic        rx_act_r;
	logic [3:0]  rx_sub_r;
	logic [3:0]  rx_idx_r;
	logic [10:0] rx_sh_r;
	logic        rx_valid_r;
	logic [10:0] tx_sh_r;
	logic [3:0]  tx_left_r;
	logic        txd_r;

	// Rate and format decode
	wire        ovs_tick = (div_r == div_of(i_baud_sel) - 12'h001);
	wire        par_en   = i_fmt_sel[1];
	wire [3:0]  rx_last  = par_en ? 4'hA : 4'h9;
	wire        rx_stop  = par_en ? rx_sh_r[10] : rx_sh_r[9];
	wire [7:0]  tx_d     = ser.tx_data;
	wire        tx_par   = (^tx_d) ^ i_fmt_sel[0];
	wire        tx_load  = ser.tx_valid && (tx_left_r == 4'h0);

	assign ser.rx_valid = rx_valid_r;
	assign ser.rx_data  = rx_sh_r[8:1];
	assign ser.rx_err   = !rx_stop || (par_en && ((^rx_sh_r[9:1]) != i_fmt_sel[0]));
	assign ser.rx_busy  = rx_act_r;
	assign ser.bit_tick = bit_tick_r;
	assign ser.tx_ready = (tx_left_r == 4'h0);
	assign ser.txd      = txd_r;

	// Oversample and bit ticks
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_r      <= 12'h000;
			sub_r      <= 4'h0;
			bit_tick_r <= 1'b0;
		end else begin
			div_r      <= ovs_tick ? 12'h000 : div_r + 12'h001;
			sub_r      <= ovs_tick ? sub_r + 4'h1 : sub_r;
			bit_tick_r <= ovs_tick && (sub_r == 4'hF);
		end
	end

	// Receiver, sampling each bit at mid-cell
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_act_r   <= 1'b0;
			rx_sub_r   <= 4'h0;
			rx_idx_r   <= 4'h0;
			rx_sh_r    <= 11'h7FF;
			rx_valid_r <= 1'b0;
		end else begin
			rx_valid_r <= 1'b0;
			if (ovs_tick && !rx_act_r && !i_rxd) begin
				rx_act_r <= 1'b1;
				rx_sub_r <= 4'h0;
				rx_idx_r <= 4'h0;
			end else if (ovs_tick && rx_act_r) begin
				rx_sub_r <= rx_sub_r + 4'h1;
				if (rx_sub_r == 4'h7 && rx_idx_r == 4'h0 && i_rxd) begin
					rx_act_r <= 1'b0; // False start
				end else if (rx_sub_r == 4'h7) begin
					rx_sh_r[rx_idx_r] <= i_rxd;
					rx_idx_r          <= rx_idx_r + 4'h1;
					rx_act_r          <= (rx_idx_r != rx_last);
					rx_valid_r        <= (rx_idx_r == rx_last);
				end
			end
		end
	end

	// Transmitter, one bit per bit tick, LSB first
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_sh_r   <= 11'h7FF;
			tx_left_r <= 4'h0;
			txd_r     <= 1'b1;
		end else if (tx_load) begin
			tx_sh_r   <= par_en ? {1'b1, tx_par, tx_d, 1'b0} : {2'b11, tx_d, 1'b0};
			tx_left_r <= (i_fmt_sel == 2'h1) ? 4'hA : 4'hB;
		end else if (bit_tick_r && tx_left_r != 4'h0) begin
			txd_r     <= tx_sh_r[0];
			tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
			tx_left_r <= tx_left_r - 4'h1;
		end
	end
endmodule

// ### hw/mbrh_read_handler.sv
// Slave frame handler for bit and register reads on a serial drive port.
// Assumes synchronous pins and a parameter store answering in one cycle.
`timescale 1ns/10ps
`include "mbrh_params.svh"
module mbrh_read_handler (
	input  wire logic               i_mclk,
	input  wire logic               i_rst_n,
	input  wire logic               i_rxd,
	input  wire logic [2:0]         i_baud_sel,
	input  wire logic [1:0]         i_fmt_sel,
	input  wire logic               i_word_order,
	input  wire mbrh_pkg::mbrh_byte_t i_slave_addr,
	input  wire logic [5:0]         i_dig_out,
	input  wire logic [33:0]        i_out_func,
	input  wire logic [31:0]        i_par_val,
	input  wire logic               i_par_wide,
	input  wire logic               i_par_slot,
	output logic                    o_txd,
	output logic                    o_tx_en,
	output logic [9:0]              o_par_group,
	output logic [6:0]              o_par_index,
	output logic                    o_frame_ok,
	output logic                    o_frame_drop
);
	import mbrh_pkg::*;

	// One readable bit by address, fixed off and on slots ahead of the function range
	function automatic logic bit_at(input logic [15:0] x, input logic [5:0] d,
		input logic [33:0] f);
		logic r;
		r = 1'b0;
		if (x >= `MBRH_DO_LO && x <= `MBRH_DO_HI)
			r = d[3'(x - `MBRH_DO_LO)];
		else if (x == `MBRH_OF_OFF)
			r = 1'b0;
		else if (x == `MBRH_OF_ON)
			r = 1'b1;
		else if (x >= `MBRH_OF_LO && x <= `MBRH_OF_HI)
			r = f[6'(x - `MBRH_OF_LO)];
		return r;
	endfunction

	// Eight bits upward from a start address, zero past the count
	function automatic logic [7:0] pack_bits(input logic [15:0] a, input logic [15:0] left,
		input logic [5:0] d, input logic [33:0] f);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (16'(i) < left)
				b[i] = bit_at(a + 16'(i), d, f);
		end
		return b;
	endfunction

	mbrh_ser_if ser ();

	mbrh_uart u_uart (
		.i_mclk     (i_mclk),
		.i_rst_n    (i_rst_n),
		.i_rxd      (i_rxd),
		.i_baud_sel (i_baud_sel),
		.i_fmt_sel  (i_fmt_sel),
		.ser        (ser.uart)
	);

	mbrh_state_t st_r;
	mbrh_state_t st_nxt;
	mbrh_byte_t  rx_buf [0:7];
	logic [3:0]  rx_cnt_r;
	logic [15:0] rx_crc_r;
	logic        rx_err_r;
	logic [5:0]  sil_r;
	logic        good_r;
	logic [3:0]  len_r;
	logic [2:0]  hdr_i_r;
	logic [7:0]  data_left_r;
	logic [15:0] bit_addr_r;
	logic [15:0] bits_left_r;
	logic [15:0] reg_addr_r;
	logic [15:0] word_r;
	logic        lo_r;
	logic [15:0] tx_crc_r;
	logic        tx_valid_r;
	mbrh_byte_t  tx_data_r;
	mbrh_byte_t  cur_byte;

	// Frame boundary from line silence
	wire [5:0] sil_lim   = (i_fmt_sel == 2'h1) ? 6'(`MBRH_SIL_BITS(`MBRH_CHAR_SHORT)) :
		6'(`MBRH_SIL_BITS(`MBRH_CHAR_LONG));
	wire       frame_end = (st_r == MBRH_ST_IDLE) && (rx_cnt_r != 4'h0) &&
		(sil_r >= sil_lim);

	// Query field decode
	wire [7:0]  fc_w     = rx_buf[1];
	wire [15:0] start_w  = {rx_buf[2], rx_buf[3]};
	wire [15:0] qty_w    = {rx_buf[4], rx_buf[5]};
	wire        is_bit   = (fc_w == `MBRH_FC_RD_BIT_A) || (fc_w == `MBRH_FC_RD_BIT_B);
	wire        is_reg   = (fc_w == `MBRH_FC_RD_REG_A) || (fc_w == `MBRH_FC_RD_REG_B);
	wire        is_w32   = (fc_w == `MBRH_FC_WR_REG32);
	wire        is_wr    = (fc_w == `MBRH_FC_WR_BIT) || (fc_w == `MBRH_FC_WR_REG16) ||
		is_w32;
	wire        len_ok   = is_w32 ? (len_r >= `MBRH_WR32_MIN) : (len_r == `MBRH_QRY_LEN);
	wire        qty_ok   = is_wr ||
		(is_bit && qty_w != 16'h0000 && qty_w <= `MBRH_MAX_BITS) ||
		(is_reg && qty_w != 16'h0000 && qty_w <= `MBRH_MAX_REGS);
	wire        addr_ok  = (rx_buf[0] == i_slave_addr) && (i_slave_addr != 8'h00);
	wire        accept   = good_r && addr_ok && (is_bit || is_reg || is_wr) &&
		len_ok && qty_ok;
	wire [7:0]  bytecnt  = is_bit ? 8'((qty_w + 16'h0007) >> 3) : 8'(qty_w << 1);
	wire [2:0]  hdr_last = is_wr ? 3'h5 : 3'h2;

	// Reply byte selection
	wire [7:0]  hdr_byte  = (!is_wr && hdr_i_r == 3'h2) ? bytecnt : rx_buf[hdr_i_r];
	wire [7:0]  bit_byte  = pack_bits(bit_addr_r, bits_left_r, i_dig_out, i_out_func);
	wire [7:0]  reg_byte  = lo_r ? word_r[7:0] : word_r[15:8];
	wire [15:0] word_sel  = !i_par_wide ? i_par_val[15:0] :
		((i_par_slot ^ i_word_order) ? i_par_val[15:0] : i_par_val[31:16]);
	wire        send_ok   = ser.tx_ready && !tx_valid_r;

	always_comb begin
		case (st_r)
			MBRH_ST_HDR:  cur_byte = hdr_byte;
			MBRH_ST_DATA: cur_byte = is_bit ? bit_byte : reg_byte;
			MBRH_ST_CRCL: cur_byte = tx_crc_r[7:0];
			MBRH_ST_CRCH: cur_byte = tx_crc_r[15:8];
			default:      cur_byte = 8'h00;
		endcase
	end

	assign ser.tx_valid = tx_valid_r;
	assign ser.tx_data  = tx_data_r;
	assign o_txd        = ser.txd;

	// Reply sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			MBRH_ST_IDLE:  if (frame_end) st_nxt = MBRH_ST_CHECK;
			MBRH_ST_CHECK: st_nxt = accept ? MBRH_ST_HDR : MBRH_ST_IDLE;
			MBRH_ST_HDR: begin
				if (send_ok && hdr_i_r == hdr_last)
					st_nxt = is_wr ? MBRH_ST_CRCL : (is_reg ? MBRH_ST_PREP : MBRH_ST_DATA);
			end
			MBRH_ST_PREP:  st_nxt = MBRH_ST_LATCH;
			MBRH_ST_LATCH: st_nxt = MBRH_ST_DATA;
			MBRH_ST_DATA: begin
				if (send_ok && data_left_r == 8'h01)
					st_nxt = MBRH_ST_CRCL;
				else if (send_ok && is_reg && lo_r)
					st_nxt = MBRH_ST_PREP;
			end
			MBRH_ST_CRCL:  if (send_ok) st_nxt = MBRH_ST_CRCH;
			MBRH_ST_CRCH:  if (send_ok) st_nxt = MBRH_ST_DONE;
			MBRH_ST_DONE:  if (send_ok && ser.bit_tick) st_nxt = MBRH_ST_IDLE;
			default:       st_nxt = MBRH_ST_IDLE;
		endcase
	end

	// Receive side: byte store, check sequence, silence count
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_cnt_r <= 4'h0;
			rx_crc_r <= `MBRH_CRC_INIT;
			rx_err_r <= 1'b0;
			sil_r    <= 6'h00;
			good_r   <= 1'b0;
			len_r    <= 4'h0;
			for (int i = 0; i < 8; i++) rx_buf[i] <= 8'h00;
		end else begin
			sil_r <= (ser.rx_busy || ser.rx_valid) ? 6'h00 :
				((ser.bit_tick && sil_r != 6'h3F) ? sil_r + 6'h01 : sil_r);
			if (frame_end) begin
				good_r   <= (rx_crc_r == 16'h0000) && !rx_err_r;
				len_r    <= rx_cnt_r;
				rx_cnt_r <= 4'h0;
				rx_crc_r <= `MBRH_CRC_INIT;
				rx_err_r <= 1'b0;
			end else if (st_r == MBRH_ST_IDLE && ser.rx_valid) begin
				if (!rx_cnt_r[3]) rx_buf[rx_cnt_r[2:0]] <= ser.rx_data;
				rx_cnt_r <= (rx_cnt_r == 4'hF) ? rx_cnt_r : rx_cnt_r + 4'h1;
				rx_crc_r <= mbrh_crc_upd(rx_crc_r, ser.rx_data);
				rx_err_r <= rx_err_r || ser.rx_err;
			end
		end
	end

	// Transmit side: counters, check sequence, byte hand-off
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r        <= MBRH_ST_IDLE;
			hdr_i_r     <= 3'h0;
			data_left_r <= 8'h00;
			bit_addr_r  <= 16'h0000;
			bits_left_r <= 16'h0000;
			reg_addr_r  <= 16'h0000;
			word_r      <= 16'h0000;
			lo_r        <= 1'b0;
			tx_crc_r    <= `MBRH_CRC_INIT;
			tx_valid_r  <= 1'b0;
			tx_data_r   <= 8'h00;
		end else begin
			st_r       <= st_nxt;
			tx_valid_r <= 1'b0;
			if (st_r == MBRH_ST_CHECK) begin
				hdr_i_r     <= 3'h0;
				data_left_r <= bytecnt;
				bit_addr_r  <= start_w;
				bits_left_r <= qty_w;
				reg_addr_r  <= start_w;
				lo_r        <= 1'b0;
				tx_crc_r    <= `MBRH_CRC_INIT;
			end
			if (st_r == MBRH_ST_LATCH) word_r <= word_sel;
			if (send_ok && st_r >= MBRH_ST_HDR && st_r <= MBRH_ST_CRCH &&
				st_r != MBRH_ST_PREP && st_r != MBRH_ST_LATCH) begin
				tx_valid_r <= 1'b1;
				tx_data_r  <= cur_byte;
			end
			if (send_ok && (st_r == MBRH_ST_HDR || st_r == MBRH_ST_DATA))
				tx_crc_r <= mbrh_crc_upd(tx_crc_r, cur_byte);
			if (send_ok && st_r == MBRH_ST_HDR) hdr_i_r <= hdr_i_r + 3'h1;
			if (send_ok && st_r == MBRH_ST_DATA) begin
				data_left_r <= data_left_r - 8'h01;
				bit_addr_r  <= bit_addr_r + 16'h0008;
				bits_left_r <= bits_left_r - 16'h0008;
				lo_r        <= !lo_r;
				if (lo_r) reg_addr_r <= reg_addr_r + 16'h0001;
			end
		end
	end

	// Registered outputs: parameter index, line driver enable, frame status
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_par_group  <= 10'h000;
			o_par_index  <= 7'h00;
			o_tx_en      <= 1'b0;
			o_frame_ok   <= 1'b0;
			o_frame_drop <= 1'b0;
		end else begin
			o_par_group  <= 10'(reg_addr_r / `MBRH_PAR_SCALE);
			o_par_index  <= 7'(reg_addr_r % `MBRH_PAR_SCALE);
			o_tx_en      <= (st_nxt != MBRH_ST_IDLE) && (st_nxt != MBRH_ST_CHECK);
			o_frame_ok   <= (st_r == MBRH_ST_CHECK) && accept;
			o_frame_drop <= (st_r == MBRH_ST_CHECK) && !accept;
		end
	end
endmodule

// ### bench/mbrh_read_handler_chk.sv
// Checker for the serial read handler: pulses, line idle level, reply timing.
// Assumes binding to the handler top; one clock domain, active-low reset.
`timescale 1ns/10ps
module mbrh_read_handler_chk (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       o_txd,
	input  wire logic       o_tx_en,
	input  wire logic [9:0] o_par_group,
	input  wire logic [6:0] o_par_index,
	input  wire logic       o_frame_ok,
	input  wire logic       o_frame_drop
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	// Held low start bit, and a driver kept off
	sequence s_start_bit;
		(!o_txd) [*8];
	endsequence
	sequence s_quiet;
		(!o_tx_en) [*8];
	endsequence

	// Outcome pulses
	a_ok_drop_excl: assert property (!(o_frame_ok && o_frame_drop))
		else $error("frame accepted and dropped at once");
	a_ok_single: assert property (o_frame_ok |=> !o_frame_ok)
		else $error("accept pulse longer than one cycle");
	a_drop_single: assert property (o_frame_drop |=> !o_frame_drop)
		else $error("drop pulse longer than one cycle");
	a_drop_silent: assert property (o_frame_drop |=> s_quiet)
		else $error("driver enabled after a dropped frame");
	// Reply framing on the line
	a_reply_follows: assert property (o_frame_ok |-> ##[0:32] o_tx_en)
		else $error("accepted frame not answered");
	a_idle_high: assert property (!o_tx_en |-> o_txd)
		else $error("line not idle high while driver off");
	a_start_bit_hold: assert property (o_tx_en && $fell(o_txd) |-> s_start_bit)
		else $error("bit on line shorter than expected");
	a_release_stop: assert property ($fell(o_tx_en) |-> o_txd && $past(o_txd))
		else $error("driver released before final stop bit");
	// Parameter address split
	// Within a reply the register pointer only steps to the next address
	a_index_step: assert property ($changed(o_par_index) && $past(o_tx_en, 2) |->
		((o_par_index == $past(o_par_index) + 7'h01) && $stable(o_par_group)) ||
		((o_par_index == 7'h00) && ($past(o_par_index) == 7'h63) &&
		(o_par_group == $past(o_par_group) + 10'h001)))
		else $error("parameter pointer did not step to next register");
endmodule

bind mbrh_read_handler mbrh_read_handler_chk chk_u (
	.i_mclk       (i_mclk),
	.i_rst_n      (i_rst_n),
	.o_txd        (o_txd),
	.o_tx_en      (o_tx_en),
	.o_par_group  (o_par_group),
	.o_par_index  (o_par_index),
	.o_frame_ok   (o_frame_ok),
	.o_frame_drop (o_frame_drop)
);

// ### bench/mbrh_master_mdl.sv
// Behavioural serial master: sends queries and collects reply bytes.
// Assumes 8N1 characters at BIT_CLKS clocks a bit; line idles high.
`timescale 1ns/10ps
module mbrh_master_mdl #(
	parameter int BIT_CLKS = 208
) (
	input  wire logic i_mclk,
	input  wire logic i_txd,
	output logic      o_rxd
);
	initial o_rxd = 1'b1;

	// Reflected check sequence, own copy
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction

	// Start, eight bits least first, one stop, at the rate code 5 pace
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_rxd = f[i];
			repeat (BIT_CLKS) @(negedge i_mclk);
		end
	endtask

	// Query with check low byte first; bad flips one check bit
	task automatic send_frame(input logic [7:0] q[$], input logic bad, input int gap);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		@(negedge i_mclk);
		foreach (q[i]) begin
			send_byte(q[i]);
			repeat (gap) @(negedge i_mclk); // Slow master, gap below silence
		end
	endtask

	// Sample one reply character at mid-bit
	task automatic recv_byte(output logic [7:0] b);
		@(negedge i_txd);
		repeat (BIT_CLKS / 2) @(negedge i_mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(negedge i_mclk);
			b[i] = i_txd;
		end
		repeat (BIT_CLKS) @(negedge i_mclk);
	endtask
endmodule

// ### bench/tb.sv
// Self-checking bench: bad check drop, bit read, wide register read.
// Assumes rate code 5 and format code 1, matching the master model.
`timescale 1ns/10ps
`define TB_CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
	import mbrh_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        rxd;
	logic        txd;
	logic        tx_en;
	logic        tx_en_q = 1'b0;
	logic        ok_q = 1'b0;
	logic [9:0]  grp_cap = 10'h000;
	logic [6:0]  idx_cap = 7'h00;
	logic        word_order;
	mbrh_byte_t  slave_addr;
	logic [5:0]  dig_out;
	logic [33:0] out_func;
	logic [31:0] par_val;
	logic        par_wide;
	logic        par_slot;
	logic [9:0]  par_group;
	logic [6:0]  par_index;
	logic        frame_ok;
	logic        frame_drop;
	int          bad_count = 0;
	int          check_count = 0;
	int          ok_cnt = 0;
	int          drop_cnt = 0;
	int          tx_starts = 0;

	mbrh_read_handler dut_u (
		.i_mclk       (clk),
		.i_rst_n      (rst_n),
		.i_rxd        (rxd),
		.i_baud_sel   (3'h5),
		.i_fmt_sel    (2'h1),
		.i_word_order (word_order),
		.i_slave_addr (slave_addr),
		.i_dig_out    (dig_out),
		.i_out_func   (out_func),
		.i_par_val    (par_val),
		.i_par_wide   (par_wide),
		.i_par_slot   (par_slot),
		.o_txd        (txd),
		.o_tx_en      (tx_en),
		.o_par_group  (par_group),
		.o_par_index  (par_index),
		.o_frame_ok   (frame_ok),
		.o_frame_drop (frame_drop)
	);

	mbrh_master_mdl mst_u (
		.i_mclk (clk),
		.i_txd  (txd),
		.o_rxd  (rxd)
	);

	// Clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Count outcome pulses and driver turn-ons; latch parameter split after accept
	always @(negedge clk) begin
		if (frame_ok === 1'b1) ok_cnt++;
		if (frame_drop === 1'b1) drop_cnt++;
		if (tx_en === 1'b1 && tx_en_q !== 1'b1) tx_starts++;
		tx_en_q = tx_en;
		if (ok_q) begin
			grp_cap = par_group;
			idx_cap = par_index;
		end
		ok_q = (frame_ok === 1'b1);
	end

	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Send a query, collect the reply and compare byte by byte
	task automatic exchange(input logic [7:0] q[$], input logic [7:0] e[$]);
		logic [7:0]  b;
		logic [15:0] c;
		c = mst_u.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		mst_u.send_frame(q, 1'b0, 0);
		foreach (e[i]) begin
			mst_u.recv_byte(b);
			`TB_CHK("reply byte", e[i], b)
		end
		repeat (2 * 208) @(negedge clk);
	endtask

	task automatic t_reset_state();
		`TB_CHK("idle line", 1'b1, txd)
		`TB_CHK("driver off", 1'b0, tx_en)
	endtask

	// Corrupted check from a slow master: no reply, one drop pulse
	task automatic t_bad_check();
		mst_u.send_frame('{8'h01, 8'h03, 8'h00, 8'h01, 8'h00, 8'h02}, 1'b1, 150);
		repeat (37 * 208) @(negedge clk);
		`TB_CHK("drop pulse", 1, drop_cnt)
		`TB_CHK("no accept", 0, ok_cnt)
		`TB_CHK("no reply", 0, tx_starts)
	endtask

	// Ten bits from 165 over fixed 166/167, padded second byte
	task automatic t_bit_read();
		@(negedge clk);
		out_func = {10'h353, 24'h0};
		exchange('{8'h01, 8'h02, 8'h00, 8'hA5, 8'h00, 8'h0A},
			'{8'h01, 8'h02, 8'h02, 8'h55, 8'h03});
		`TB_CHK("accept pulse", 1, ok_cnt)
		`TB_CHK("one reply", 1, tx_starts)
	endtask

	// Register 2021, first slot of a wide value, lower half first
	task automatic t_reg_read();
		@(negedge clk);
		word_order = 1'b1;
		par_wide = 1'b1;
		par_slot = 1'b0;
		par_val = 32'h1234_ABCD;
		exchange('{8'h01, 8'h04, 8'h07, 8'hE5, 8'h00, 8'h01},
			'{8'h01, 8'h04, 8'h02, 8'hAB, 8'hCD});
		`TB_CHK("param group", 10'h014, grp_cap)
		`TB_CHK("param index", 7'h15, idx_cap)
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		word_order = 1'b0;
		slave_addr = 8'h01;
		dig_out = 6'h2D;
		out_func = 34'h0;
		par_val = 32'h0;
		par_wide = 1'b0;
		par_slot = 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset_state();
		t_bad_check();
		t_bit_read();
		t_reg_read();
		end_of_test();
	end

	// Watchdog past the expected run length
	initial begin
		repeat (120000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
